// ---- rtl/tx_modulator.sv ----
// Transmit back end: I/Q attenuation, quadrature modulation, fine gain, DAC feed.
// Assumes core_clk_in is the DAC sample clock; I/Q source is on the same clock.
// Summary of operation
// - Output equals I times carrier cosine minus Q times carrier sine.
// - I and Q are scaled by about -3 dB before modulation.
// - One 12-bit sample reaches the converter every sample clock.
// - Input is taken once per four sample clocks; latencies count sample clocks.
// - Input change first shows at the converter 119 sample clocks later.
// - A constant input settles at the converter within 176 sample clocks.
// - Carrier switch after profile pin change completes in under 232 clocks.
// - Four-bit fine gain scales output from -7.5 dB in 0.5 dB steps.
// - Active profile comes from the pin, or from select bit 0 when select bit 1 is set.
`default_nettype none
module tx_modulator
  import tx_mod_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire iq_type iq_in,
  output logic iq_take_out,
  input wire logic profile_pin_in,
  input wire logic [1:0] profile_sel_in,
  input wire ftw_set_type ftw_in,
  input wire logic [3:0] dac_gain_in,
  output sample_type dac_out,
  output logic active_profile_out
);
  // ==========================================================
  // State
  core_state_type r;
  core_state_type next_r;
  iq_type lag_iq;
  logic signed [24:0] att_i_prod;
  logic signed [24:0] att_q_prod;
  logic signed [24:0] mod_sum;
  logic signed [13:0] mod_scaled;
  logic signed [25:0] gain_prod;
  logic [LUT_W-1:0] lut_ph;

  iq_delay_mem iq_delay_mem_i (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .wr_addr_in(r.wptr),
    .rd_addr_in(r.wptr - PTR_W'(MEM_LAG)),
    .wr_data_in(r.hold),
    .rd_data_out(lag_iq)
  );

  assign iq_take_out = (r.phase == PHASE_TAKE);

  // ==========================================================
  // Datapath
  always_comb
  begin
    next_r = r;
    next_r.phase = r.phase + 2'h1;
    next_r.wptr = r.wptr + PTR_W'(1);
    // Zero-order hold between interface samples
    if (iq_take_out)
      next_r.hold = iq_in;
    // Pin counts once the second and third stages agree
    next_r.pin_sync = {r.pin_sync[1:0], profile_pin_in};
    if (r.pin_sync[1] == r.pin_sync[2])
      next_r.pin_stable = r.pin_sync[2];
    // Select bit 1 overrides the pin with select bit 0
    next_r.profile = profile_sel_in[1] ? profile_sel_in[0] : r.pin_stable;
    // New tuning word acts on the very next step; no phase reset, so no jump
    next_r.acc = r.acc + ftw_in[r.profile];
    lut_ph = r.acc[FTW_W-1 -: LUT_W];
    next_r.sin_c = sine_of(lut_ph);
    next_r.cos_c = sine_of(lut_ph + QUARTER);
    att_i_prod = lag_iq.i * ATT_COEF;
    att_q_prod = lag_iq.q * ATT_COEF;
    next_r.att.i = att_i_prod[ATT_SHIFT +: SAMPLE_W];
    next_r.att.q = att_q_prod[ATT_SHIFT +: SAMPLE_W];
    mod_sum = 25'(r.att.i * r.cos_c) - 25'(r.att.q * r.sin_c);
    mod_scaled = mod_sum[MOD_SHIFT +: 14];
    if (mod_scaled > 14'(SAMPLE_MAX))
      next_r.mod = SAMPLE_MAX;
    else if (mod_scaled < 14'(SAMPLE_MIN))
      next_r.mod = SAMPLE_MIN;
    else
      next_r.mod = mod_scaled[SAMPLE_W-1:0];
    gain_prod = r.mod * $signed({1'b0, gain_coef(dac_gain_in)});
    next_r.dac = gain_prod[GAIN_SHIFT +: SAMPLE_W];
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      r <= '0;
    else
      r <= next_r;
  end

  assign dac_out = r.dac;
  assign active_profile_out = r.profile;

  // ==========================================================
  // Checks
  logic [7:0] fill_cnt;
  logic [8:0] still_cnt;
  logic [8:0] hop_cnt;
  logic hop_wait;

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      fill_cnt <= 8'h00;
      still_cnt <= 9'h000;
      hop_cnt <= 9'h000;
      hop_wait <= 1'b0;
    end
    else
    begin
      if (fill_cnt != 8'hFF)
        fill_cnt <= fill_cnt + 8'h01;
      if (iq_take_out && iq_in != r.hold)
        still_cnt <= 9'h000;
      else if (still_cnt != 9'h1FF)
        still_cnt <= still_cnt + 9'h001;
      if (!profile_sel_in[1] && r.pin_stable != r.profile)
        hop_wait <= 1'b1;
      else if (r.pin_stable == r.profile)
        hop_wait <= 1'b0;
      hop_cnt <= hop_wait ? hop_cnt + 9'h001 : 9'h000;
    end
  end

  sequence s_take;
    iq_take_out;
  endsequence
  sequence s_gap;
    !iq_take_out [*3] ##1 iq_take_out;
  endsequence

  a_take_rate: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) s_take |=> s_gap)
    else $error("input take not every four clocks");
  // A word written one edge after its take comes back out of the read register one lag later
  a_iq_lag: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    fill_cnt > 8'h78 |-> lag_iq == $past(r.hold, 116))
    else $error("lag memory delay wrong");
  a_att_scale: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    fill_cnt > 8'h02 |-> 25'($signed(r.att.i)) == ($past(lag_iq.i) * ATT_COEF) >>> ATT_SHIFT)
    else $error("I attenuation wrong");
  // Recomputed in wide arithmetic, so a narrow or mis-signed sum in the datapath shows up
  a_mod_formula: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    fill_cnt > 8'h03 && r.mod != SAMPLE_MAX && r.mod != SAMPLE_MIN |->
    32'(r.mod) == (32'($past(r.att.i)) * 32'($past(r.cos_c)) - 32'($past(r.att.q)) * 32'($past(r.sin_c)))
    >>> MOD_SHIFT)
    else $error("modulator sum wrong");
  a_no_wrap: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    fill_cnt > 8'h03 && $past(mod_sum) > 0 |-> r.mod >= 0)
    else $error("modulator output wrapped");
  a_gain_scale: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    fill_cnt > 8'h04 && $past(dac_gain_in) == 4'hF |-> dac_out == $past(r.mod))
    else $error("full gain code not unity");
  a_dac_feed: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    fill_cnt > 8'h04 |-> 26'($signed(dac_out)) ==
    ($past(r.mod) * $signed({1'b0, gain_coef($past(dac_gain_in))})) >>> GAIN_SHIFT)
    else $error("converter sample wrong");
  a_dc_settle: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    still_cnt >= 9'(SETTLE_CYC) && fill_cnt == 8'hFF |-> $stable(r.att))
    else $error("constant input not settled");
  a_hop_time: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    hop_cnt < 9'(HOP_CYC))
    else $error("profile switch too slow");
  a_profile_pick: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    $past(profile_sel_in[1]) |-> active_profile_out == $past(profile_sel_in[0]))
    else $error("profile select bits ignored");
endmodule : tx_modulator
`default_nettype wire

// ---- rtl/tx_mod_pkg.sv ----
// Shared constants, types and tables for the transmit modulator back end.
// Assumes one sample clock; the interface rate is derived from it by division.
`default_nettype none
package tx_mod_pkg;
  localparam int SAMPLE_W = 12;
  localparam int FTW_W = 26;
  localparam int PROFILES = 2;
  localparam int RATE_MULT = 4;
  localparam int LAT_CYC = 119;
  localparam int SETTLE_CYC = 176;
  localparam int HOP_CYC = 232;
  localparam int PIPE_CYC = 4;
  localparam int MEM_LAG = LAT_CYC - PIPE_CYC;
  localparam int MEM_DEPTH = 128;
  localparam int PTR_W = 7;
  localparam int ATT_SHIFT = 12;
  localparam int MOD_SHIFT = 11;
  localparam int GAIN_SHIFT = 12;
  localparam int LUT_W = 6;
  localparam logic signed [12:0] ATT_COEF = 13'sh0B50;
  localparam logic [LUT_W-1:0] QUARTER = 6'h10;
  localparam logic [1:0] PHASE_TAKE = 2'h0;
  localparam logic signed [SAMPLE_W-1:0] SAMPLE_MAX = 12'sh7FF;
  localparam logic signed [SAMPLE_W-1:0] SAMPLE_MIN = -12'sh800;

  typedef logic signed [SAMPLE_W-1:0] sample_type;
  typedef struct packed {
    sample_type i;
    sample_type q;
  } iq_type;
  typedef logic [PROFILES-1:0][FTW_W-1:0] ftw_set_type;

  typedef struct packed {
    logic [1:0] phase;
    iq_type hold;
    logic [2:0] pin_sync;
    logic pin_stable;
    logic profile;
    logic [FTW_W-1:0] acc;
    sample_type cos_c;
    sample_type sin_c;
    iq_type att;
    sample_type mod;
    sample_type dac;
    logic [PTR_W-1:0] wptr;
  } core_state_type;

  typedef struct packed {
    logic [MEM_DEPTH-1:0][2*SAMPLE_W-1:0] word;
    iq_type rdata;
  } mem_state_type;

  // Quarter wave of sine, full scale 2047, 16 steps
  function automatic logic [SAMPLE_W-1:0] quarter_sine(input logic [3:0] idx);
    unique case (idx)
      4'h0: quarter_sine = 12'h000;
      4'h1: quarter_sine = 12'h0C9;
      4'h2: quarter_sine = 12'h18F;
      4'h3: quarter_sine = 12'h252;
      4'h4: quarter_sine = 12'h30F;
      4'h5: quarter_sine = 12'h3C5;
      4'h6: quarter_sine = 12'h471;
      4'h7: quarter_sine = 12'h513;
      4'h8: quarter_sine = 12'h5A7;
      4'h9: quarter_sine = 12'h62E;
      4'hA: quarter_sine = 12'h6A6;
      4'hB: quarter_sine = 12'h70D;
      4'hC: quarter_sine = 12'h763;
      4'hD: quarter_sine = 12'h7A7;
      4'hE: quarter_sine = 12'h7D8;
      4'hF: quarter_sine = 12'h7F5;
    endcase
  endfunction : quarter_sine

  function automatic sample_type sine_of(input logic [LUT_W-1:0] ph);
    logic [SAMPLE_W-1:0] mag;
    mag = ph[4] ? quarter_sine(~ph[3:0]) : quarter_sine(ph[3:0]);
    sine_of = ph[5] ? -$signed(mag) : $signed(mag);
  endfunction : sine_of

  // Fine gain 10^((-7.5 + 0.5 N)/20) in units of 1/4096
  function automatic logic [12:0] gain_coef(input logic [3:0] n);
    unique case (n)
      4'h0: gain_coef = 13'h06BF;
      4'h1: gain_coef = 13'h0726;
      4'h2: gain_coef = 13'h0792;
      4'h3: gain_coef = 13'h0805;
      4'h4: gain_coef = 13'h087F;
      4'h5: gain_coef = 13'h08FF;
      4'h6: gain_coef = 13'h0988;
      4'h7: gain_coef = 13'h0A18;
      4'h8: gain_coef = 13'h0AB2;
      4'h9: gain_coef = 13'h0B54;
      4'hA: gain_coef = 13'h0C00;
      4'hB: gain_coef = 13'h0CB6;
      4'hC: gain_coef = 13'h0D76;
      4'hD: gain_coef = 13'h0E43;
      4'hE: gain_coef = 13'h0F1B;
      4'hF: gain_coef = 13'h1000;
    endcase
  endfunction : gain_coef
endpackage : tx_mod_pkg
`default_nettype wire

// ---- rtl/iq_delay_mem.sv ----
// Circular sample memory giving the fixed datapath lag.
// Assumes the owner steps the write pointer every clock.
`default_nettype none
module iq_delay_mem
  import tx_mod_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [PTR_W-1:0] wr_addr_in,
  input wire logic [PTR_W-1:0] rd_addr_in,
  input wire iq_type wr_data_in,
  output iq_type rd_data_out
);
  mem_state_type r;
  mem_state_type next_r;

  always_comb
  begin
    next_r = r;
    next_r.word[wr_addr_in] = wr_data_in;
    next_r.rdata = r.word[rd_addr_in];
  end

  // Contents are cleared so the first lag period emits zeros, not garbage
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      r <= '0;
    else
      r <= next_r;
  end

  assign rd_data_out = r.rdata;
endmodule : iq_delay_mem
`default_nettype wire

// ---- tb/iq_source.sv ----
// Baseband I/Q source model that feeds the modulator input.
// Assumes the bench sets next_in before the falling edge on which a take loads it.
`default_nettype none
module iq_source
  import tx_mod_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic take_in,
  input wire iq_type next_in,
  output iq_type iq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Drive
  // No start value: reset holds the take strobe high, so the first falling edge loads next_in
  // Word is scrambled outside take cycles, so a stray capture is caught
  always @(negedge core_clk_in)
  begin
    iq_out <= take_in ? next_in : ~iq_out;
  end
endmodule : iq_source
`default_nettype wire

// ---- tb/tx_modulator_tb.sv ----
// Self-checking bench for the transmit modulator back end.
// Assumes a 20 MHz sample clock and two tuning words at the port.
`default_nettype none
module tx_modulator_tb;
  import tx_mod_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  iq_type next_iq = '0;
  iq_type iq;
  logic take;
  logic pin = 1'b0;
  logic [1:0] sel = 2'h0;
  ftw_set_type ftw = {26'h0400000, 26'h0000000};
  logic [3:0] gain = 4'hF;
  sample_type dac;
  logic prof;
  int bad_count = 0;
  int n_compared = 0;
  // ==========
  // Structure
  iq_source iq_source_i (.core_clk_in(core_clk_in), .take_in(take), .next_in(next_iq), .iq_out(iq));
  tx_modulator tx_modulator_i (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .iq_in(iq),
    .iq_take_out(take), .profile_pin_in(pin), .profile_sel_in(sel), .ftw_in(ftw),
    .dac_gain_in(gain), .dac_out(dac), .active_profile_out(prof));
  always #25 core_clk_in = ~core_clk_in;
  // ==========
  // Helpers
  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  // Rounding of carrier and gain tables is allowed a few LSBs
  function automatic logic [11:0] near(input sample_type v, input int e);
    // An unknown sample would read as zero through int, so it must fail here
    if ($isunknown(v))
      return 12'h000;
    return (int'(v) - e <= 12 && e - int'(v) <= 12) ? 12'h001 : 12'h000;
  endfunction : near
  task automatic put(input sample_type i, input sample_type q);
    @(posedge core_clk_in);
    #1 next_iq = '{i, q};
  endtask : put
  // ==========
  // Scenarios
  task automatic t_latency;
    int n = 0;
    repeat (40)
    begin
      @(posedge core_clk_in);
      #1 n += int'(take);
    end
    check(12'(n), 12'h00A, "take rate");
    put(SAMPLE_MAX, 12'sh000);
    @(negedge core_clk_in iff take);
    repeat (119) @(posedge core_clk_in);
    #1 check(dac, 12'h000, "early change");
    @(posedge core_clk_in);
    #1 check(near(dac, 1447), 12'h001, "first response");
    repeat (57) @(posedge core_clk_in);
    #1 check(near(dac, 1447), 12'h001, "settled dc");
    $display("test latency done");
  endtask : t_latency
  task automatic t_gain;
    logic [3:0] code [4] = '{4'h0, 4'h5, 4'hA, 4'hF};
    int want [4] = '{610, 814, 1085, 1447};
    for (int k = 0; k < 4; k++)
    begin
      @(negedge core_clk_in);
      gain = code[k];
      repeat (3) @(posedge core_clk_in);
      #1 check(near(dac, want[k]), 12'h001, "fine gain step");
    end
    $display("test gain done");
  endtask : t_gain
  task automatic t_mod;
    put(12'sh000, SAMPLE_MAX);
    repeat (180) @(posedge core_clk_in);
    #1 check(near(dac, 0), 12'h001, "q times zero sine");
    put(SAMPLE_MIN, SAMPLE_MAX);
    repeat (180) @(posedge core_clk_in);
    #1 check(near(dac, -1448), 12'h001, "negative full scale");
    put(SAMPLE_MAX, 12'sh000);
    repeat (180) @(posedge core_clk_in);
    #1 check(near(dac, 1447), 12'h001, "i times cosine");
    $display("test modulation done");
  endtask : t_mod
  task automatic t_profile;
    int lo = 4096;
    int hi = -4096;
    @(negedge core_clk_in);
    sel = 2'h2;
    pin = 1'b1;
    repeat (20) @(posedge core_clk_in);
    #1 check({11'h000, prof}, 12'h000, "pin while forced");
    @(negedge core_clk_in);
    sel = 2'h3;
    repeat (2) @(posedge core_clk_in);
    #1 check({11'h000, prof}, 12'h001, "select bit profile");
    @(negedge core_clk_in);
    sel = 2'h0;
    pin = 1'b0;
    repeat (10) @(posedge core_clk_in);
    #1 check({11'h000, prof}, 12'h000, "pin low profile");
    @(negedge core_clk_in);
    pin = 1'b1;
    // A frozen carrier gives a flat output; the spinning one swings wide
    repeat (231)
    begin
      @(posedge core_clk_in);
      #1 lo = (int'(dac) < lo) ? int'(dac) : lo;
      hi = (int'(dac) > hi) ? int'(dac) : hi;
    end
    check({11'h000, prof}, 12'h001, "pin hop profile");
    check({11'h000, hi - lo > 2000}, 12'h001, "hop carrier swing");
    $display("test profile done");
  endtask : t_profile
  // ==========
  // Verdict
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (20) @(negedge core_clk_in);
    rst_b_in = 1'b1;
    t_latency();
    t_gain();
    t_mod();
    t_profile();
    tally_and_finish();
  end
  initial
  begin
    #(50 * 4000);
    bad_count++;
    tally_and_finish();
  end
endmodule : tx_modulator_tb
`default_nettype wire
